/* File: design/char_disp_pkg.sv */
// Constants for the character display controller: register map, fields, geometry.
// Assumes nothing beyond an SV tool; used by char_glyph_cursor_addressing.
package char_disp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSTR = 8'h04;
  localparam logic [7:0] OFS_GLYPH_ADDR = 8'h08;
  localparam logic [7:0] OFS_GLYPH_DATA = 8'h0C;
  localparam logic [7:0] OFS_TEXT_DATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Control fields
  localparam int CTRL_TWO_LINE = 0;
  localparam int CTRL_FONT10 = 1;
  localparam int CTRL_CURSOR = 2;
  localparam int CTRL_BLINK = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Instruction word fields
  localparam int INSTR_CA_BIT = 7;
  // Status fields
  localparam int STAT_AC_LSB = 0;
  localparam int STAT_GP_LSB = 8;
  localparam int STAT_ROW_LSB = 16;
  localparam int STAT_BLINK = 24;
  // Geometry
  localparam int TEXT_DEPTH = 128;
  localparam int GLYPH_DEPTH = 64;
  localparam int DOTS = 5;
  localparam int CHARS = 20;
  localparam int SEGS = 100;
  localparam int COMS = 16;
  localparam logic [4:0] ROWS8 = 5'h08;
  localparam logic [4:0] ROWS10 = 5'h0B;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [4:0] ALL_DOTS = 5'h1F;
  localparam logic [3:0] USER_CODE_HI = 4'h0;
  localparam int BLINK_FRAMES = 32;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Refresh states
  typedef enum logic [1:0] {
    ST_SCAN = 2'b01,
    ST_LATCH = 2'b10
  } refresh_state_t;
endpackage

/* File: design/char_glyph_cursor_addressing.sv */
// Character display refresh with glyph RAM, text RAM, cursor and blink, plus AXI4-Lite slave.
// Assumes one synchronous clock, a host master on AXI4-Lite, and drivers outside taking seg/com levels.
`timescale 1ns/1ps
`default_nettype none
module char_glyph_cursor_addressing #(
  parameter int BLINK_FRAMES = char_disp_pkg::BLINK_FRAMES
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Display drive
  output logic [char_disp_pkg::SEGS-1:0] segOut,
  output logic [char_disp_pkg::COMS-1:0] comSel
);
  if (BLINK_FRAMES < 2 || BLINK_FRAMES > 255)
  begin : g_chk
    $error("BLINK_FRAMES must lie in 2..255");
  end

  function automatic logic [5:0] glyphAddr(input logic font10, input logic [7:0] code, input logic [3:0] line);
    if (font10)
      glyphAddr = {code[2:1], line};
    else
      glyphAddr = {code[2:0], line[2:0]};
  endfunction

  // Storage
  logic [char_disp_pkg::DOTS-1:0] glyphRam [char_disp_pkg::GLYPH_DEPTH];
  logic [7:0] textRam [char_disp_pkg::TEXT_DEPTH];

  // Control state
  logic [3:0] ctrl_reg;
  logic [6:0] addrCounter_reg, addrCounter_next;
  logic [5:0] glyphPtr_reg;
  logic twoLineMode;
  logic font10;

  // AXI state
  logic awHave_reg;
  logic wHave_reg;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Refresh state
  char_disp_pkg::refresh_state_t state_reg, state_next;
  logic [4:0] charIdx_reg;
  logic [3:0] rowIdx_reg, rowIdx_next;
  logic [char_disp_pkg::SEGS-1:0] segAcc_reg;
  logic [char_disp_pkg::SEGS-1:0] segOut_reg;
  logic [char_disp_pkg::COMS-1:0] comSel_reg;
  logic [7:0] blinkCnt_reg;
  logic blinkPhase_reg;

  assign twoLineMode = ctrl_reg[char_disp_pkg::CTRL_TWO_LINE] & ~font10;
  assign font10 = ctrl_reg[char_disp_pkg::CTRL_FONT10];

  // Write decode
  wire doWrite = awHave_reg & wHave_reg & ~bvalid_reg;
  wire lowLane = wStrb_reg[0];
  wire hitCtrl = awAddr_reg == char_disp_pkg::OFS_CTRL;
  wire hitInstr = awAddr_reg == char_disp_pkg::OFS_INSTR;
  wire hitGAddr = awAddr_reg == char_disp_pkg::OFS_GLYPH_ADDR;
  wire hitGData = awAddr_reg == char_disp_pkg::OFS_GLYPH_DATA;
  wire hitText = awAddr_reg == char_disp_pkg::OFS_TEXT_DATA;
  wire wrMapped = hitCtrl | hitInstr | hitGAddr | hitGData | hitText;
  wire wrEn = doWrite & wrMapped & lowLane;
  wire loadAc = wrEn & hitInstr & wData_reg[char_disp_pkg::INSTR_CA_BIT];
  wire textWr = wrEn & hitText;
  wire glyphWr = wrEn & hitGData;

  assign addrCounter_next = loadAc ? wData_reg[6:0]
    : !textWr ? addrCounter_reg
    : twoLineMode ? {addrCounter_reg[6], addrCounter_reg[5:0] + 6'h01}
    : addrCounter_reg + 7'h01;

  // Read decode
  wire arTake = s_axi_arvalid & arready_reg;
  wire rdCtrl = s_axi_araddr == char_disp_pkg::OFS_CTRL;
  wire rdInstr = s_axi_araddr == char_disp_pkg::OFS_INSTR;
  wire rdStat = s_axi_araddr == char_disp_pkg::OFS_STATUS;
  wire rdMapped = rdCtrl | rdInstr | rdStat | (s_axi_araddr == char_disp_pkg::OFS_GLYPH_ADDR);
  wire [31:0] statWord = (32'(addrCounter_reg) << char_disp_pkg::STAT_AC_LSB)
    | (32'(glyphPtr_reg) << char_disp_pkg::STAT_GP_LSB)
    | (32'(rowIdx_reg) << char_disp_pkg::STAT_ROW_LSB)
    | (32'(blinkPhase_reg) << char_disp_pkg::STAT_BLINK);
  wire [31:0] rdWord = rdCtrl ? 32'(ctrl_reg)
    : rdInstr ? 32'(addrCounter_reg)
    : rdStat ? statWord
    : 32'(glyphPtr_reg);

  // AXI handshake
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= char_disp_pkg::RESP_OKAY;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end
    else
    begin
      awready_reg <= ~awHave_reg & ~(s_axi_awvalid & awready_reg) & ~doWrite;
      wready_reg <= ~wHave_reg & ~(s_axi_wvalid & wready_reg) & ~doWrite;
      if (s_axi_awvalid & awready_reg)
      begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      else if (doWrite)
        awHave_reg <= 1'b0;
      if (s_axi_wvalid & wready_reg)
      begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      else if (doWrite)
        wHave_reg <= 1'b0;
      if (doWrite)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wrMapped ? char_disp_pkg::RESP_OKAY : char_disp_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= char_disp_pkg::RESP_OKAY;
    end
    else
    begin
      arready_reg <= ~rvalid_reg & ~arTake;
      if (arTake)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rdMapped ? rdWord : 32'h0000_0000;
        rresp_reg <= rdMapped ? char_disp_pkg::RESP_OKAY : char_disp_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_reg <= char_disp_pkg::CTRL_RESET;
      addrCounter_reg <= 7'h00;
      glyphPtr_reg <= 6'h00;
    end
    else
    begin
      addrCounter_reg <= addrCounter_next;
      if (wrEn & hitCtrl)
        ctrl_reg <= wData_reg[3:0];
      if (wrEn & hitGAddr)
        glyphPtr_reg <= wData_reg[5:0];
      else if (glyphWr)
        glyphPtr_reg <= glyphPtr_reg + 6'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (glyphWr)
      glyphRam[glyphPtr_reg] <= wData_reg[char_disp_pkg::DOTS-1:0];
    if (textWr)
      textRam[addrCounter_reg] <= wData_reg[7:0];
  end

  // Refresh geometry
  wire [4:0] fontRows = font10 ? char_disp_pkg::ROWS10 : char_disp_pkg::ROWS8;
  wire [4:0] activeRows = twoLineMode ? 5'(fontRows << 1) : fontRows;
  wire lineSel = 5'(rowIdx_reg) >= fontRows;
  wire rowInRange = 5'(rowIdx_reg) < activeRows;
  wire [3:0] lineRow = lineSel ? 4'(5'(rowIdx_reg) - fontRows) : rowIdx_reg;
  wire [6:0] textAddr = (lineSel ? char_disp_pkg::LINE2_BASE : 7'h00) + 7'(charIdx_reg);
  wire [7:0] code = textRam[textAddr];
  wire isUser = code[7:4] == char_disp_pkg::USER_CODE_HI;
  wire [5:0] gAddr = glyphAddr(font10, code, lineRow);
  wire [4:0] pattern = isUser ? glyphRam[gAddr] : 5'h00;
  wire cursorHit = textAddr == addrCounter_reg;
  wire cursorLine = 5'(lineRow) == fontRows - 5'h01;
  wire [4:0] cursorDots = (ctrl_reg[char_disp_pkg::CTRL_CURSOR] & cursorHit & cursorLine)
    ? char_disp_pkg::ALL_DOTS : 5'h00;
  wire [4:0] blinkDots = (ctrl_reg[char_disp_pkg::CTRL_BLINK] & cursorHit & blinkPhase_reg)
    ? char_disp_pkg::ALL_DOTS : 5'h00;
  wire [4:0] dots = pattern | cursorDots | blinkDots;
  wire lastChar = charIdx_reg == 5'(char_disp_pkg::CHARS - 1);
  wire frameEnd = (state_reg == char_disp_pkg::ST_LATCH) & (5'(rowIdx_next) == 5'h00);

  assign state_next = (state_reg == char_disp_pkg::ST_SCAN) & lastChar ? char_disp_pkg::ST_LATCH
    : char_disp_pkg::ST_SCAN;
  assign rowIdx_next = (5'(rowIdx_reg) + 5'h01 >= activeRows) ? 4'h0 : rowIdx_reg + 4'h1;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_reg <= char_disp_pkg::ST_SCAN;
      charIdx_reg <= 5'h00;
      rowIdx_reg <= 4'h0;
      segAcc_reg <= '0;
      segOut_reg <= '0;
      comSel_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      case (state_reg)
        char_disp_pkg::ST_SCAN:
        begin
          segAcc_reg <= {segAcc_reg[char_disp_pkg::SEGS-char_disp_pkg::DOTS-1:0], dots};
          charIdx_reg <= lastChar ? 5'h00 : charIdx_reg + 5'h01;
        end
        char_disp_pkg::ST_LATCH:
        begin
          segOut_reg <= segAcc_reg;
          comSel_reg <= char_disp_pkg::COMS'(1) << (rowInRange ? rowIdx_reg : 4'h0);
          rowIdx_reg <= rowIdx_next;
        end
        default:
          charIdx_reg <= 5'h00;
      endcase
    end
  end

  // Blink timing in frames
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      blinkCnt_reg <= 8'h00;
      blinkPhase_reg <= 1'b0;
    end
    else if (frameEnd)
    begin
      blinkCnt_reg <= (blinkCnt_reg == 8'(BLINK_FRAMES - 1)) ? 8'h00 : blinkCnt_reg + 8'h01;
      if (blinkCnt_reg == 8'(BLINK_FRAMES - 1))
        blinkPhase_reg <= ~blinkPhase_reg;
    end
  end

  // Glyph pointer mode leaves cursor at counter address, meaningless
  // Outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign segOut = segOut_reg;
  assign comSel = comSel_reg;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  wire scanning = state_reg == char_disp_pkg::ST_SCAN;
  wire [char_disp_pkg::COMS-1:0] activeMask = char_disp_pkg::COMS'((17'h1 << activeRows) - 17'h1);

  addr_five8_a: assert property (!font10 |-> gAddr[5:3] == code[2:0] && gAddr[2:0] == lineRow[2:0])
    else $error("5x8 glyph address wrong");
  addr_five10_a: assert property (font10 |-> gAddr[5:4] == code[2:1] && gAddr[3:0] == lineRow)
    else $error("5x10 glyph address wrong");
  rom_dark_a: assert property (scanning && !isUser && !cursorHit |=> segAcc_reg[4:0] == 5'h00)
    else $error("non-user code lit dots");
  dots_shift_a: assert property (scanning && !cursorHit |=> segAcc_reg[4:0] === $past(pattern))
    else $error("dot data not shifted in");
  cursor_line_a: assert property (scanning && cursorHit && cursorLine && ctrl_reg[char_disp_pkg::CTRL_CURSOR]
    |=> segAcc_reg[4:0] == char_disp_pkg::ALL_DOTS)
    else $error("cursor line not lit");
  seg_latch_a: assert property (state_reg == char_disp_pkg::ST_LATCH |=> segOut_reg === $past(segAcc_reg)
    && $onehot(comSel_reg))
    else $error("row latch wrong");
  unused_com_a: assert property (state_reg == char_disp_pkg::ST_LATCH |=> (comSel_reg & ~$past(activeMask)) == '0)
    else $error("unused common selected");
  second_line_a: assert property (lineSel |-> textAddr[6] && textAddr[5:0] == 6'(charIdx_reg))
    else $error("second line address wrong");
  ac_load_a: assert property (loadAc |=> addrCounter_reg == $past(wData_reg[6:0]))
    else $error("address counter not loaded");
  ac_wrap_a: assert property (textWr && !loadAc && twoLineMode |=> addrCounter_reg[6] == $past(addrCounter_reg[6]))
    else $error("two-line counter left its line");
  resp_hold_a: assert property (bvalid_reg && !s_axi_bready |=> bvalid_reg && $stable(bresp_reg))
    else $error("write response dropped");
  two_line_c: cover property (twoLineMode && frameEnd);
  font10_cursor_c: cover property (font10 && cursorLine && cursorHit && scanning);
  blink_c: cover property (frameEnd && blinkPhase_reg);
  slverr_c: cover property (bvalid_reg && bresp_reg == char_disp_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

/* File: verification/host_axi_master.sv */
// Host model: an AXI4-Lite master that runs one write or one read at a time.
// Assumes the slave answers on its own schedule; only the bench timeout ends a hang.
`timescale 1ns/1ps
`default_nettype none
module host_axi_master (
  // Clock
  input wire logic clk_sys,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w))
    begin
      @(posedge clk_sys);
      if (!aw && awready)
      begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready)
      begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk_sys);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic setCounter(input logic [6:0] a);
    logic [1:0] r;
    wr(char_disp_pkg::OFS_INSTR, {24'h0, 1'b1, a}, r);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Bench: programs the display controller through the host model and checks every refresh row.
// Assumes the package and design compile first; blink phase shortened to 2 frames, a 4-frame blink period.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys;
  logic srst;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [99:0] segOut;
  logic [15:0] comSel;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] lfsr = 8'h23;
  logic [7:0] txt [128];
  logic [4:0] gly [64];
  logic [6:0] cnt;
  logic two, f10, curOn;
  logic [31:0] rv;
  logic [3:0] cfgCtrl [4] = '{4'h4, 4'h5, 4'h1, 4'h7};
  logic [6:0] cfgCnt [4] = '{7'h0E, 7'h46, 7'h46, 7'h03};

  host_axi_master HOST (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  char_glyph_cursor_addressing #(.BLINK_FRAMES(2)) DUT (.clk_sys(clk_sys), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .segOut(segOut), .comSel(comSel));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chkVal(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chkSeg(input logic [99:0] g, input logic [99:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    HOST.rd(a, rv, rs);
    chkVal(rv, d);
    chkVal(32'(rs), 32'(r));
  endtask

  task automatic wrChk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    HOST.wr(a, d, rs);
    chkVal(32'(rs), 32'(r));
  endtask

  task automatic putText(input logic [7:0] c);
    wrChk(char_disp_pkg::OFS_TEXT_DATA, 32'(c), char_disp_pkg::RESP_OKAY);
    txt[cnt] = c;
    cnt = two ? {cnt[6], cnt[5:0] + 6'h01} : cnt + 7'h01;
  endtask

  task automatic setMode(input logic [3:0] v, input logic [6:0] a);
    wrChk(char_disp_pkg::OFS_CTRL, 32'(v), char_disp_pkg::RESP_OKAY);
    {curOn, f10, two} = v[2:0];
    HOST.setCounter(a);
    cnt = a;
  endtask

  function automatic logic [99:0] expSeg(input int r);
    logic [99:0] s;
    int a;
    int ln;
    logic [7:0] c;
    logic [4:0] d;
    s = '0;
    for (int k = 0; k < 20; k++)
    begin
      a = (two && !f10 && r >= 8) ? 64 + k : k;
      ln = (two && !f10) ? r % 8 : r;
      c = txt[a];
      d = 5'h00;
      if (c[7:4] == 4'h0)
        d = f10 ? gly[{c[2:1], 4'(ln)}] : gly[{c[2:0], 3'(ln)}];
      if (curOn && a == cnt && ln == (f10 ? 10 : 7))
        d = d | 5'h1F;
      s[99 - 5 * k -: 5] = d;
    end
    return s;
  endfunction

  task automatic checkFrame();
    int rows;
    int row;
    int prev;
    int n;
    logic [15:0] last;
    rows = f10 ? 11 : (two ? 16 : 8);
    prev = -1;
    repeat (700) @(negedge clk_sys);
    last = comSel;
    for (int i = 0; i <= rows; i++)
    begin
      n = 0;
      while (comSel === last && n < 40)
      begin
        @(negedge clk_sys);
        n++;
      end
      last = comSel;
      row = $clog2(comSel);
      chkVal(32'(n <= 21), 32'h1);
      chkVal(32'(comSel), 32'h1 << row);
      chkVal(32'(row < rows), 32'h1);
      if (prev >= 0)
        chkVal(32'(row), 32'((prev + 1) % rows));
      prev = row;
      chkSeg(segOut, expSeg(row));
    end
  endtask

  initial
  begin
    srst = 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    rdChk(char_disp_pkg::OFS_CTRL, 32'h0, char_disp_pkg::RESP_OKAY);
    rdChk(char_disp_pkg::OFS_INSTR, 32'h0, char_disp_pkg::RESP_OKAY);
    rdChk(8'h20, 32'h0, char_disp_pkg::RESP_SLVERR);
    wrChk(char_disp_pkg::OFS_STATUS, 32'h1, char_disp_pkg::RESP_SLVERR);
    wrChk(char_disp_pkg::OFS_GLYPH_ADDR, 32'h0, char_disp_pkg::RESP_OKAY);
    for (int i = 0; i < 64; i++)
    begin
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      gly[i] = lfsr[4:0];
      if (i % 8 == 7 || i % 16 == 10)
        gly[i] = 5'h00;
      wrChk(char_disp_pkg::OFS_GLYPH_DATA, 32'(gly[i]), char_disp_pkg::RESP_OKAY);
    end
    rdChk(char_disp_pkg::OFS_GLYPH_ADDR, 32'h0, char_disp_pkg::RESP_OKAY);
    setMode(4'h0, 7'h00);
    for (int i = 0; i < 40; i++)
    begin
      if (i == 20)
        HOST.setCounter(7'h40);
      if (i == 20)
        cnt = 7'h40;
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      putText(lfsr & 8'h1F);
    end
    rdChk(char_disp_pkg::OFS_INSTR, 32'h54, char_disp_pkg::RESP_OKAY);
    HOST.setCounter(7'h7F);
    putText(8'h31);
    rdChk(char_disp_pkg::OFS_INSTR, 32'h00, char_disp_pkg::RESP_OKAY);
    setMode(4'h1, 7'h7F);
    putText(8'h32);
    rdChk(char_disp_pkg::OFS_INSTR, 32'h40, char_disp_pkg::RESP_OKAY);
    wrChk(char_disp_pkg::OFS_INSTR, 32'h05, char_disp_pkg::RESP_OKAY);
    rdChk(char_disp_pkg::OFS_INSTR, 32'h40, char_disp_pkg::RESP_OKAY);
    for (int j = 0; j < 4; j++)
    begin
      setMode(cfgCtrl[j], cfgCnt[j]);
      rdChk(char_disp_pkg::OFS_CTRL, 32'(cfgCtrl[j]), char_disp_pkg::RESP_OKAY);
      rdChk(char_disp_pkg::OFS_INSTR, 32'(cfgCnt[j]), char_disp_pkg::RESP_OKAY);
      checkFrame();
    end
    results();
  end
endmodule
`default_nettype wire
